// ### pkg/fir_regs_defines.vh
// register indexes, field positions and reset values of the fir register bank
// assumes a 32-bit apb bus whose byte address is four times the register index
//
// Operation
// - filter x bank: 128 rw bytes from 0x0E00, reset zero
// - filter y bank: 128 rw bytes from 0x0F00, reset zero
// - new coefficients reach the filter only after transfer bit 0 of 0x000F
// - 0x0701 bit 7 is first calibration enable, 1 enables, resets 0
// - 0x073B bit 7 is second calibration control, 0 enables, resets 1
// - 0x18E3 bits 5:0 rw common-mode buffer setting, reset zero
// - three-bit filter mode chooses bypass, x, xy, cascade or real 96-tap
`ifndef FIR_REGS_DEFINES_VH
`define FIR_REGS_DEFINES_VH

// register indexes; a register sits at byte address index times four
`define IDX_TRANSFER       14'h000F
`define IDX_FILT_MODE      14'h0DF8
`define IDX_CAL_ONE        14'h0701
`define IDX_CAL_TWO        14'h073B
`define IDX_REF_SEL        14'h18A6
`define IDX_CM_BUF         14'h18E3
`define IDX_X_BANK         14'h0E00
`define IDX_Y_BANK         14'h0F00
`define BANK_MASK          14'h3F80

// field positions
`define TRANSFER_BIT       0
`define CAL_EN_BIT         7
`define REF_SEL_BIT        0
`define CM_ENABLE_BIT      6
`define CM_SETTING_MSB     5
`define MODE_MSB           2

// reset values
`define COEFF_RESET        8'h00
`define MODE_RESET         3'h0
`define CAL_ONE_EN_RESET   1'h0
`define CAL_ONE_RSVD_RESET 7'h06
`define CAL_TWO_EN_RESET   1'h1
`define CAL_TWO_RSVD_RESET 7'h3F
`define REF_SEL_RESET      1'h0
`define CM_ENABLE_RESET    1'h0
`define CM_SETTING_RESET   6'h00

// filter mode codes
`define MODE_BYPASS      3'h0
`define MODE_X_ONLY      3'h1
`define MODE_XY          3'h2
`define MODE_CASCADE     3'h4
`define MODE_REAL96      3'h7

`endif

// ### rtl/fir_coeff_regs.v
// apb register bank for fir coefficient shadow/active sets and front-end bits
// assumes an apb master on clk; the register index is paddr[15:2]
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fir_regs_defines.vh"

module fir_coeff_regs (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [15:0] paddr,
	input  wire [31:0] pwdata,
	input  wire [3:0]  pstrb,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	// filter side: active coefficient set, index selects one tap pair
	input  wire [6:0]  coeff_index,
	output reg  [7:0]  coeff_x,
	output reg  [7:0]  coeff_y,
	output reg  [2:0]  filter_mode,
	output reg         transfer_done,
	// front-end controls
	output reg         cal_enable_one,
	output reg         cal_control_two,
	output reg         ref_external,
	output reg         cm_buffer_enable,
	output reg  [5:0]  cm_buffer_setting
);

	// coefficient storage: shadow takes bus writes, active feeds the filter
	reg  [7:0]  shadow_x [0:127];
	reg  [7:0]  shadow_y [0:127];
	reg  [7:0]  active_x [0:127];
	reg  [7:0]  active_y [0:127];
	reg  [31:0] next_prdata;
	integer     i;
	integer     j;

	// true when a register index lies in the 128-entry bank at base
	function in_bank;
		input [13:0] index;
		input [13:0] base;
		begin
			in_bank = ((index & `BANK_MASK) == base);
		end
	endfunction

	// true when an aligned access names exactly the target register
	function hits;
		input [13:0] index;
		input        word;
		input [13:0] target;
		begin
			hits = word & (index == target);
		end
	endfunction

	// address decode; misaligned byte addresses map to nothing
	wire [13:0] reg_index   = paddr[15:2];
	wire [6:0]  tap         = paddr[8:2];
	wire        aligned     = (paddr[1:0] == 2'h0);
	wire        setup       = psel & ~penable;
	wire        access      = psel & penable;
	wire        wr          = access & pwrite & pstrb[0];
	wire        hit_xfer    = hits(reg_index, aligned, `IDX_TRANSFER);
	wire        hit_mode    = hits(reg_index, aligned, `IDX_FILT_MODE);
	wire        hit_cal_one = hits(reg_index, aligned, `IDX_CAL_ONE);
	wire        hit_cal_two = hits(reg_index, aligned, `IDX_CAL_TWO);
	wire        hit_ref     = hits(reg_index, aligned, `IDX_REF_SEL);
	wire        hit_cm      = hits(reg_index, aligned, `IDX_CM_BUF);
	wire        in_x        = aligned & in_bank(reg_index, `IDX_X_BANK);
	wire        in_y        = aligned & in_bank(reg_index, `IDX_Y_BANK);
	wire        mapped      = hit_xfer | hit_mode | hit_cal_one |
	                          hit_cal_two | hit_ref | hit_cm |
	                          in_x | in_y;
	wire        xfer        = wr & hit_xfer & pwdata[`TRANSFER_BIT];

	// zero wait states; unmapped accesses are refused and write nothing
	assign pready  = 1'h1;
	assign pslverr = access & ~mapped;

	// shadow banks take bus writes; the filter never sees them directly
	always @(posedge clk) begin
		if (rst) begin
			for (i = 0; i < 128; i = i + 1) begin
				shadow_x[i] <= `COEFF_RESET;
				shadow_y[i] <= `COEFF_RESET;
			end
		end else begin
			if (wr & in_x)
				shadow_x[tap] <= pwdata[7:0];
			if (wr & in_y)
				shadow_y[tap] <= pwdata[7:0];
		end
	end

	// active sets change only on a transfer, every tap in the same cycle
	always @(posedge clk) begin
		if (rst) begin
			for (j = 0; j < 128; j = j + 1) begin
				active_x[j] <= `COEFF_RESET;
				active_y[j] <= `COEFF_RESET;
			end
		end else if (xfer) begin
			for (j = 0; j < 128; j = j + 1) begin
				active_x[j] <= shadow_x[j];
				active_y[j] <= shadow_y[j];
			end
		end
	end

	// one-cycle marker that a transfer was taken; the bit is not stored
	always @(posedge clk) begin
		if (rst) begin
			transfer_done <= 1'h0;
		end else begin
			transfer_done <= xfer;
		end
	end

	// filter mode field
	always @(posedge clk) begin
		if (rst) begin
			filter_mode <= `MODE_RESET;
		end else if (wr & hit_mode) begin
			filter_mode <= pwdata[`MODE_MSB:0];
		end
	end

	// first calibration enable, set means enabled
	always @(posedge clk) begin
		if (rst) begin
			cal_enable_one <= `CAL_ONE_EN_RESET;
		end else if (wr & hit_cal_one) begin
			cal_enable_one <= pwdata[`CAL_EN_BIT];
		end
	end

	// second calibration control, clear means enabled
	always @(posedge clk) begin
		if (rst) begin
			cal_control_two <= `CAL_TWO_EN_RESET;
		end else if (wr & hit_cal_two) begin
			cal_control_two <= pwdata[`CAL_EN_BIT];
		end
	end

	// reference source select, set means external
	always @(posedge clk) begin
		if (rst) begin
			ref_external <= `REF_SEL_RESET;
		end else if (wr & hit_ref) begin
			ref_external <= pwdata[`REF_SEL_BIT];
		end
	end

	// common-mode buffer enable and setting share one register
	always @(posedge clk) begin
		if (rst) begin
			cm_buffer_enable  <= `CM_ENABLE_RESET;
			cm_buffer_setting <= `CM_SETTING_RESET;
		end else if (wr & hit_cm) begin
			cm_buffer_enable  <= pwdata[`CM_ENABLE_BIT];
			cm_buffer_setting <= pwdata[`CM_SETTING_MSB:0];
		end
	end

	// filter reads only the active set, one cycle after the index
	always @(posedge clk) begin
		if (rst) begin
			coeff_x <= `COEFF_RESET;
			coeff_y <= `COEFF_RESET;
		end else begin
			coeff_x <= active_x[coeff_index];
			coeff_y <= active_y[coeff_index];
		end
	end

	// read mux; transfer reads zero and banks read back the shadow copy
	always @* begin
		next_prdata = 32'h00000000;
		if (hit_mode) begin
			next_prdata[`MODE_MSB:0] = filter_mode;
		end else if (hit_cal_one) begin
			next_prdata[7:0] = {cal_enable_one, `CAL_ONE_RSVD_RESET};
		end else if (hit_cal_two) begin
			next_prdata[7:0] = {cal_control_two, `CAL_TWO_RSVD_RESET};
		end else if (hit_ref) begin
			next_prdata[`REF_SEL_BIT] = ref_external;
		end else if (hit_cm) begin
			next_prdata[7:0] = {1'h0, cm_buffer_enable, cm_buffer_setting};
		end else if (in_x) begin
			next_prdata[7:0] = shadow_x[tap];
		end else if (in_y) begin
			next_prdata[7:0] = shadow_y[tap];
		end
	end

	// read data is taken in the setup cycle and stands through the access
	// phase; a write in the previous access is already visible here
	always @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			prdata <= next_prdata;
		end
	end

endmodule

`default_nettype wire

// ### test/fir_regs_assertions.sv
// checker for the fir coefficient register bank
// assumes binding into fir_coeff_regs; byte address is four times the index
`timescale 1ns/100ps
`default_nettype none
module fir_regs_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// apb request and refusal
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pslverr,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	// design outputs and the coefficient index input
	input wire logic        transfer_done,
	input wire logic        cal_enable_one,
	input wire logic        cal_control_two,
	input wire logic [6:0]  coeff_index,
	input wire logic [7:0]  coeff_x,
	input wire logic [2:0]  filter_mode,
	input wire logic [5:0]  cm_buffer_setting
);
	wire wr = psel && penable && pwrite && pstrb[0];
	wire xf = wr && paddr == 16'h003C && pwdata[0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	cal_reset_a: assert property (disable iff (1'b0) rst
		|=> !cal_enable_one && cal_control_two) else $error("cal reset");
	xfer_pulse_a: assert property (xf |=> transfer_done)
		else $error("no transfer pulse");
	coeff_hold_a: assert property ($stable(coeff_index) && !$past(xf)
		|=> $stable(coeff_x)) else $error("coeff moved");
	cal_one_a: assert property (wr && paddr == 16'h1C04
		|=> cal_enable_one == $past(pwdata[7])) else $error("cal one");
	cal_two_a: assert property (wr && paddr == 16'h1CEC
		|=> cal_control_two == $past(pwdata[7])) else $error("cal two");
	cm_set_a: assert property (wr && paddr == 16'h638C
		|=> cm_buffer_setting == $past(pwdata[5:0])) else $error("cm");
	mode_set_a: assert property (wr && paddr == 16'h37E0
		|=> filter_mode == $past(pwdata[2:0])) else $error("mode");
	bank_map_a: assert property (psel && penable && !paddr[9]
		&& paddr[15:11] == 5'h07 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("bank unmapped");
endmodule
bind fir_coeff_regs fir_regs_checker fir_regs_checker_inst (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .transfer_done(transfer_done),
	.cal_enable_one(cal_enable_one), .cal_control_two(cal_control_two),
	.coeff_index(coeff_index), .coeff_x(coeff_x),
	.filter_mode(filter_mode), .cm_buffer_setting(cm_buffer_setting)
);
`default_nettype wire

// ### test/tb_top.sv
// self-checking bench for fir_coeff_regs over apb
// assumes synchronous reset; apb byte address is four times the index
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
	logic        pready, pslverr, transfer_done, cal_enable_one;
	logic        cal_control_two, ref_external, cm_buffer_enable;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	logic [6:0]  coeff_index = 7'h0;
	logic [7:0]  coeff_x, coeff_y;
	logic [2:0]  filter_mode, modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
	logic [5:0]  cm_buffer_setting;
	int          num_errors = 0, cmp_count = 0;
	fir_coeff_regs fir_coeff_regs_inst (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.coeff_index(coeff_index), .coeff_x(coeff_x), .coeff_y(coeff_y),
		.filter_mode(filter_mode), .transfer_done(transfer_done),
		.cal_enable_one(cal_enable_one), .cal_control_two(cal_control_two),
		.ref_external(ref_external), .cm_buffer_enable(cm_buffer_enable),
		.cm_buffer_setting(cm_buffer_setting)
	);
	task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wrap_up;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial forever #2 clk = ~clk;
	initial begin
		#20000;
		num_errors++;
		wrap_up;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		acc(0, 16'h1C04, 0); chk(rd, 32'h06);
		acc(0, 16'h1CEC, 0); chk(rd, 32'hBF);
		acc(0, 16'h3DFC, 0); chk(rd, 32'h0);
		acc(0, 16'h638C, 0); chk(rd, 32'h0);
		acc(0, 16'h6298, 0); chk(rd, 32'h0);
		acc(1, 16'h3804, 32'h5A);
		acc(1, 16'h3C04, 32'hA5);
		acc(1, 16'h39FC, 32'h3C);
		acc(0, 16'h3804, 0); chk(rd, 32'h5A);
		acc(0, 16'h39FC, 0); chk(rd, 32'h3C);
		acc(0, 16'h3C04, 0); chk(rd, 32'hA5);
		coeff_index <= 7'h01;
		repeat (2) @(negedge clk);
		chk({coeff_x, coeff_y}, 32'h0);
		acc(1, 16'h003C, 32'h1);
		repeat (2) @(negedge clk);
		chk({coeff_x, coeff_y}, 32'h5AA5);
		@(posedge clk);
		coeff_index <= 7'h7F;
		repeat (2) @(negedge clk);
		chk({coeff_x, coeff_y}, 32'h3C00);
		acc(0, 16'h003C, 0); chk(rd, 32'h0);
		acc(1, 16'h3804, 32'h11);
		coeff_index <= 7'h01;
		repeat (2) @(negedge clk);
		chk({coeff_x, coeff_y}, 32'h5AA5);
		acc(1, 16'h1C04, 32'h80); acc(1, 16'h1CEC, 32'h0);
		@(negedge clk);
		chk({cal_enable_one, cal_control_two}, 32'h2);
		acc(0, 16'h1C04, 0); chk(rd, 32'h86);
		acc(0, 16'h1CEC, 0); chk(rd, 32'h3F);
		acc(1, 16'h6298, 32'h1);
		@(negedge clk);
		chk(ref_external, 32'h1);
		acc(0, 16'h6298, 0); chk(rd, 32'h1);
		acc(1, 16'h638C, 32'h7F);
		@(negedge clk);
		chk({cm_buffer_enable, cm_buffer_setting}, 32'h7F);
		acc(0, 16'h638C, 0); chk(rd, 32'h7F);
		foreach (modes[i]) begin
			acc(1, 16'h37E0, {29'h0, modes[i]});
			@(negedge clk);
			chk(filter_mode, modes[i]);
		end
		acc(0, 16'h1234, 0);
		chk(rd, 32'h0);
		chk(er, 32'h1);
		wrap_up;
	end
endmodule
`default_nettype wire
